/* File: rtl/isrw_map.svh */
/*
  Constants for the ISA slave ready and width decode block: I/O decode
  addresses, pin sense levels and reset values.
  Assumes inclusion by bare name from the package and design modules.
*/
`ifndef ISRW_MAP_SVH
`define ISRW_MAP_SVH

`define ISRW_IO_LO       16'h03B0
`define ISRW_IO_HI       16'h03DF
`define ISRW_SEQ_IDX     16'h03C4
`define ISRW_SEQ_DAT     16'h03C5
`define ISRW_GC_IDX      16'h03CE
`define ISRW_GC_DAT      16'h03CF
`define ISRW_CRT_MIDX    16'h03B4
`define ISRW_CRT_MDAT    16'h03B5
`define ISRW_CRT_CIDX    16'h03D4
`define ISRW_CRT_CDAT    16'h03D5
`define ISRW_STAT1_M     16'h03BA
`define ISRW_STAT1_C     16'h03DA
`define ISRW_PIN_RST_VAL 1'h1
`define ISRW_SYNC_STAGES 2

`endif

/* File: rtl/isrw_pkg.sv */
/*
  Types shared by the ISA slave ready and width decode block.
  Assumes isrw_map.svh is on the include path.
*/
`include "isrw_map.svh"

package isrw_pkg;
  typedef enum logic [2:0] {
    ISRW_IDLE    = 3'b000,
    ISRW_RD_WAIT = 3'b001,
    ISRW_RD_HOLD = 3'b010,
    ISRW_WR_WAIT = 3'b011,
    ISRW_WR_HOLD = 3'b100,
    ISRW_IO_HOLD = 3'b101
  } isrw_rdy_e;

  typedef logic [15:0] isrw_addr_t;
endpackage

/* File: rtl/isrw_dec_if.sv */
/*
  Carrier between the top module and its address decoder.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps

interface isrw_dec_if;
  logic [15:0] addr;
  logic        aen;
  logic        io_hit;
  logic        cs16_hit;

  modport owner (output addr, output aen, input io_hit, input cs16_hit);
  modport dec   (input addr, input aen, output io_hit, output cs16_hit);
endinterface

/* File: rtl/isrw_addr_decode.sv */
/*
  Combinational I/O address decode: range hit and 16-bit width hit.
  Assumes address and aen are already synchronised to clk.
*/
`timescale 1ns/1ps

module isrw_addr_decode
  import isrw_pkg::*;
(
  isrw_dec_if.dec d
);
  `include "isrw_map.svh"

  function automatic logic is_wide(input isrw_addr_t a);
    is_wide = (a == `ISRW_SEQ_IDX)  || (a == `ISRW_SEQ_DAT)  ||
              (a == `ISRW_GC_IDX)   || (a == `ISRW_GC_DAT)   ||
              (a == `ISRW_CRT_MIDX) || (a == `ISRW_CRT_MDAT) ||
              (a == `ISRW_CRT_CIDX) || (a == `ISRW_CRT_CDAT) ||
              (a == `ISRW_STAT1_M)  || (a == `ISRW_STAT1_C);
  endfunction

  always_comb begin
    d.io_hit   = !d.aen && (d.addr >= `ISRW_IO_LO) && (d.addr <= `ISRW_IO_HI);
    d.cs16_hit = !d.aen && is_wide(d.addr);
  end
endmodule

/* File: rtl/isrw_slave.sv */
/*
  ISA slave front end of a flat-panel VGA controller: ready line,
  16-bit I/O width indication, I/O register read and write strobes.
  Assumes ISA strobes, address and data arrive asynchronously from the
  bus pins; register file and write buffer status come from core logic
  on clk. Pins are split into input, output and active-low enable.
*/
`timescale 1ns/1ps

// What this block does
// - ready stays high during I/O and BIOS reads to us.
// - memory read: ready low at strobe fall, high when data ready, float after.
// - memory write with buffer space: ready driven high, no wait.
// - memory write with full buffer: ready low until an entry frees.
// - stalled write: ready high once space frees, float after strobe rises.
// - width indication only ever pulled low, open collector.
// - width indication decoded from address and address enable.
// - width asserted for sequencer, graphics, CRT and status-one addresses.
// - I/O read in range drives addressed register onto data bus.
// - address enable high: ignore I/O cycles, memory side unaffected.
// - I/O write latches data while strobe low, pulses write strobe after it rises.
module isrw_slave
  import isrw_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [15:0] sa,
  input  wire logic        aen,
  input  wire logic        ior_n,
  input  wire logic        iow_n,
  input  wire logic        smemr_n,
  input  wire logic        smemw_n,
  input  wire logic        bios_sel,
  input  wire logic [15:0] sd_i,
  input  wire logic        rd_data_ready,
  input  wire logic        wbuf_full,
  input  wire logic [15:0] reg_rd_data,
  output logic             iochrdy_o,
  output logic             iochrdy_oe_n,
  output logic             iocs16_o,
  output logic             iocs16_oe_n,
  output logic [15:0]      sd_o,
  output logic             sd_oe_n,
  output logic [15:0]      reg_addr,
  output logic             reg_rd_en,
  output logic             reg_wr_stb,
  output logic [15:0]      reg_wr_data
);
  `include "isrw_map.svh"

  // two-stage pin synchronisers
  logic [15:0] sa_s1_q,  sa_s2_q;
  logic [15:0] sd_s1_q,  sd_s2_q;
  logic [5:0]  pin_s1_q, pin_s2_q;
  logic        ior_nq,   iow_nq, smemr_nq, smemw_nq, aen_q, bios_q;
  logic        iow_prev_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      sa_s1_q    <= 16'h0000;
      sa_s2_q    <= 16'h0000;
      sd_s1_q    <= 16'h0000;
      sd_s2_q    <= 16'h0000;
      pin_s1_q   <= 6'h1F;
      pin_s2_q   <= 6'h1F;
      iow_prev_q <= `ISRW_PIN_RST_VAL;
    end else begin
      sa_s1_q    <= sa;
      sa_s2_q    <= sa_s1_q;
      sd_s1_q    <= sd_i;
      sd_s2_q    <= sd_s1_q;
      pin_s1_q   <= {bios_sel, aen, smemw_n, smemr_n, iow_n, ior_n};
      pin_s2_q   <= pin_s1_q;
      iow_prev_q <= pin_s2_q[1];
    end
  end

  always_comb begin
    ior_nq   = pin_s2_q[0];
    iow_nq   = pin_s2_q[1];
    smemr_nq = pin_s2_q[2];
    smemw_nq = pin_s2_q[3];
    aen_q    = pin_s2_q[4];
    bios_q   = pin_s2_q[5];
  end

  isrw_dec_if dif ();

  assign dif.addr = sa_s2_q;
  assign dif.aen  = aen_q;

  isrw_addr_decode u_dec (
    .d (dif.dec)
  );

  // ready state machine
  isrw_rdy_e st_q, st_d;
  logic      rdy_q, rdy_d;
  logic      rdy_oe_n_q, rdy_oe_n_d;
  logic      io_rd;

  always_comb begin
    io_rd      = !ior_nq && dif.io_hit;
    st_d       = st_q;
    rdy_d      = rdy_q;
    rdy_oe_n_d = rdy_oe_n_q;
    case (st_q)
      ISRW_IDLE: begin
        rdy_d      = 1'b1;
        rdy_oe_n_d = 1'b1;
        if (!smemr_nq && !bios_q) begin
          st_d       = ISRW_RD_WAIT;
          rdy_d      = 1'b0;
          rdy_oe_n_d = 1'b0;
        end else if (!smemw_nq && wbuf_full) begin
          st_d       = ISRW_WR_WAIT;
          rdy_d      = 1'b0;
          rdy_oe_n_d = 1'b0;
        end else if (!smemw_nq) begin
          st_d       = ISRW_WR_HOLD;
          rdy_d      = 1'b1;
          rdy_oe_n_d = 1'b0;
        end else if (io_rd || (!smemr_nq && bios_q)) begin
          st_d       = ISRW_IO_HOLD;
          rdy_d      = 1'b1;
          rdy_oe_n_d = 1'b0;
        end
      end
      ISRW_RD_WAIT: begin
        if (smemr_nq) begin
          st_d       = ISRW_IDLE;
          rdy_d      = 1'b1;
          rdy_oe_n_d = 1'b1;
        end else if (rd_data_ready) begin
          st_d  = ISRW_RD_HOLD;
          rdy_d = 1'b1;
        end
      end
      ISRW_WR_WAIT: begin
        if (smemw_nq) begin
          st_d       = ISRW_IDLE;
          rdy_d      = 1'b1;
          rdy_oe_n_d = 1'b1;
        end else if (!wbuf_full) begin
          st_d  = ISRW_WR_HOLD;
          rdy_d = 1'b1;
        end
      end
      ISRW_RD_HOLD: begin
        if (smemr_nq) begin
          st_d       = ISRW_IDLE;
          rdy_oe_n_d = 1'b1;
        end
      end
      ISRW_WR_HOLD: begin
        if (smemw_nq) begin
          st_d       = ISRW_IDLE;
          rdy_oe_n_d = 1'b1;
        end
      end
      ISRW_IO_HOLD: begin
        if (!io_rd && smemr_nq) begin
          st_d       = ISRW_IDLE;
          rdy_oe_n_d = 1'b1;
        end
      end
      default: begin
        st_d       = ISRW_IDLE;
        rdy_d      = 1'b1;
        rdy_oe_n_d = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_q       <= ISRW_IDLE;
      rdy_q      <= 1'b1;
      rdy_oe_n_q <= 1'b1;
    end else begin
      st_q       <= st_d;
      rdy_q      <= rdy_d;
      rdy_oe_n_q <= rdy_oe_n_d;
    end
  end

  assign iochrdy_o    = rdy_q;
  assign iochrdy_oe_n = rdy_oe_n_q;

  // I/O register access and width indication
  logic        cs16_oe_n_q, cs16_oe_n_d;
  logic [15:0] sd_q, sd_d;
  logic        sd_oe_n_q, sd_oe_n_d;
  logic [15:0] addr_q, addr_d;
  logic        rd_en_q, rd_en_d;
  logic        wr_stb_q, wr_stb_d;
  logic [15:0] wr_data_q, wr_data_d;
  logic        wr_hit_q,  wr_hit_d;

  always_comb begin
    cs16_oe_n_d = !dif.cs16_hit;
    sd_oe_n_d   = !io_rd;
    sd_d        = io_rd ? reg_rd_data : sd_q;
    rd_en_d     = io_rd;
    addr_d      = addr_q;
    wr_data_d   = wr_data_q;
    wr_stb_d    = 1'b0;
    wr_hit_d    = !iow_nq && dif.io_hit;
    if (io_rd) begin
      addr_d = sa_s2_q;
    end
    if (!iow_nq && dif.io_hit) begin
      addr_d    = sa_s2_q;
      wr_data_d = sd_s2_q;
    end
    if (iow_nq && !iow_prev_q && !aen_q && wr_hit_q) begin
      wr_stb_d = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cs16_oe_n_q <= 1'b1;
      sd_q        <= 16'h0000;
      sd_oe_n_q   <= 1'b1;
      addr_q      <= 16'h0000;
      rd_en_q     <= 1'b0;
      wr_stb_q    <= 1'b0;
      wr_data_q   <= 16'h0000;
      wr_hit_q    <= 1'b0;
    end else begin
      cs16_oe_n_q <= cs16_oe_n_d;
      sd_q        <= sd_d;
      sd_oe_n_q   <= sd_oe_n_d;
      addr_q      <= addr_d;
      rd_en_q     <= rd_en_d;
      wr_stb_q    <= wr_stb_d;
      wr_data_q   <= wr_data_d;
      wr_hit_q    <= wr_hit_d;
    end
  end

  assign iocs16_o    = 1'b0;
  assign iocs16_oe_n = cs16_oe_n_q;
  assign sd_o        = sd_q;
  assign sd_oe_n     = sd_oe_n_q;
  assign reg_addr    = addr_q;
  assign reg_rd_en   = rd_en_q;
  assign reg_wr_stb  = wr_stb_q;
  assign reg_wr_data = wr_data_q;
endmodule

/* File: sim/isrw_slave_sva.sv */
/* Port checker for isrw_slave: ready line, width line, read drive.
   Assumes binding to isrw_slave and the 3-edge pin latency. */
`timescale 1ns/1ps
`include "isrw_map.svh"

module isrw_slave_chk (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic [15:0] sa,
  input wire logic        aen,
  input wire logic        ior_n,
  input wire logic        iow_n,
  input wire logic        smemr_n,
  input wire logic        smemw_n,
  input wire logic        bios_sel,
  input wire logic        rd_data_ready,
  input wire logic        wbuf_full,
  input wire logic [15:0] reg_rd_data,
  input wire logic        iochrdy_o,
  input wire logic        iochrdy_oe_n,
  input wire logic        iocs16_oe_n,
  input wire logic [15:0] sd_o,
  input wire logic        sd_oe_n,
  input wire logic        reg_wr_stb
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  function automatic logic cs_hit(input logic [15:0] a, input logic e);
    return !e && (a inside {16'h03C4, 16'h03C5, 16'h03CE, 16'h03CF, 16'h03B4,
                            16'h03B5, 16'h03D4, 16'h03D5, 16'h03BA, 16'h03DA});
  endfunction

  AST_MRD_LOW: assert property ($fell(smemr_n) && !bios_sel && !rd_data_ready
    |-> ##3 !iochrdy_oe_n && !iochrdy_o) else $error("ready not low on memory read");
  AST_RDY_RISE: assert property (!smemr_n && smemw_n && !iochrdy_oe_n && !iochrdy_o
    && rd_data_ready |=> iochrdy_o && !iochrdy_oe_n) else $error("ready not raised on data");
  AST_WR_NOWAIT: assert property ($fell(smemw_n) && smemr_n ##2 !wbuf_full
    |=> !iochrdy_oe_n && iochrdy_o) else $error("write with space waited");
  AST_WR_STALL: assert property ($fell(smemw_n) && smemr_n ##2 wbuf_full
    |=> !iochrdy_oe_n && !iochrdy_o) else $error("full buffer write not stalled");
  AST_WR_RESUME: assert property (!smemw_n && smemr_n && !iochrdy_oe_n && !iochrdy_o
    && !wbuf_full |=> iochrdy_o && !iochrdy_oe_n) else $error("stalled write not resumed");
  AST_RDY_FLOAT: assert property ($rose(smemr_n) || $rose(smemw_n) || $rose(ior_n)
    |-> ##3 iochrdy_oe_n) else $error("ready not floated after cycle");
  AST_IO_RDY: assert property ($fell(ior_n) && !aen && sa inside {[`ISRW_IO_LO:`ISRW_IO_HI]}
    |-> ##3 !iochrdy_oe_n && iochrdy_o && !sd_oe_n) else $error("io read not answered");
  AST_SD_DATA: assert property (!sd_oe_n && !$past(sd_oe_n)
    |-> sd_o == $past(reg_rd_data)) else $error("read data not register contents");
  AST_CS16: assert property ($stable({sa, aen})[*5]
    |-> iocs16_oe_n == !cs_hit(sa, aen)) else $error("width line wrong for address");
  AST_WR_STB: assert property ($rose(iow_n) && !aen && sa inside {[`ISRW_IO_LO:`ISRW_IO_HI]}
    |-> ##[2:5] reg_wr_stb) else $error("io write gave no strobe");
endmodule

bind isrw_slave isrw_slave_chk chk_u (.clk, .rst, .sa, .aen, .ior_n, .iow_n, .smemr_n,
  .smemw_n, .bios_sel, .rd_data_ready, .wbuf_full, .reg_rd_data, .iochrdy_o, .iochrdy_oe_n,
  .iocs16_oe_n, .sd_o, .sd_oe_n, .reg_wr_stb);

/* File: sim/isrw_host.sv */
/* Bus master model driving strobes, address and data.
   Assumes rdy is the resolved ready wire with its pull-up. */
`timescale 1ns/1ps

module isrw_host (
  input  wire logic        clk,
  input  wire logic        rdy,
  output logic [15:0]      sa,
  output logic             aen,
  output logic             ior_n,
  output logic             iow_n,
  output logic             smemr_n,
  output logic             smemw_n,
  output logic [15:0]      sd_i
);
  initial begin
    sa = 16'h0000;
    aen = 1'b0;
    {smemr_n, smemw_n, ior_n, iow_n} = 4'hF;
    sd_i = 16'h0000;
  end

  // kind 0 mem read, 1 mem write, 2 io read, 3 io write
  task automatic cyc(input logic [1:0] k, input logic [15:0] a, d, input logic e);
    @(posedge clk);
    #5;
    sa = a;
    aen = e;
    case (k)
      2'h0: smemr_n = 1'b0;
      2'h1: smemw_n = 1'b0;
      2'h2: ior_n = 1'b0;
      default: begin
        iow_n = 1'b0;
        sd_i = d;
      end
    endcase
    repeat (5) @(posedge clk);
    while (rdy !== 1'b1) @(posedge clk);
    #5;
    {smemr_n, smemw_n, ior_n, iow_n} = 4'hF;
    @(posedge clk);
    #5;
    // released data bus shows no stale value
    sd_i = ~sd_i;
    repeat (3) @(posedge clk);
  endtask
endmodule

/* File: sim/isrw_slave_tb.sv */
/* Bench for isrw_slave: memory, io and width cycles from a host model.
   Assumes a pull-up on the ready line. */
`timescale 1ns/1ps

module isrw_slave_tb;
  logic        clk, rst, bios_sel, rd_data_ready, wbuf_full;
  logic [15:0] reg_rd_data, sd_o, reg_addr, reg_wr_data;
  logic        iochrdy_o, iochrdy_oe_n, iocs16_oe_n, sd_oe_n, reg_wr_stb;
  logic        iocs16_o, reg_rd_en;
  wire  [15:0] sa, sd_i;
  wire         aen, ior_n, iow_n, smemr_n, smemw_n;
  wire         rdy = iochrdy_oe_n ? 1'b1 : iochrdy_o;
  int          failures = 0, check_count = 0, cyc_n = 0, stb_cnt = 0;
  logic [15:0] io_tbl [12] = '{16'h03C4, 16'h03C5, 16'h03CE, 16'h03CF, 16'h03B4, 16'h03B5,
                               16'h03D4, 16'h03D5, 16'h03BA, 16'h03DA, 16'h03C0, 16'h0300};

  isrw_host host_u (.clk, .rdy, .sa, .aen, .ior_n, .iow_n, .smemr_n, .smemw_n, .sd_i);
  isrw_slave dut_u (.clk, .rst, .sa, .aen, .ior_n, .iow_n, .smemr_n, .smemw_n, .bios_sel,
    .sd_i, .rd_data_ready, .wbuf_full, .reg_rd_data, .iochrdy_o, .iochrdy_oe_n,
    .iocs16_o, .iocs16_oe_n, .sd_o, .sd_oe_n, .reg_addr, .reg_rd_en, .reg_wr_stb,
    .reg_wr_data);

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  always @(posedge clk) begin
    cyc_n++;
    if (reg_wr_stb === 1'b1) stb_cnt++;
    if (cyc_n == 5000) begin
      failures++;
      tally_and_finish;
    end
  end

  task t_mem_rd;
    fork
      host_u.cyc(2'h0, 16'h0000, 16'h0000, 1'b0);
      begin
        repeat (5) @(posedge clk);
        #5;
        chk({14'h0, iochrdy_oe_n, rdy}, 16'h0000);
        repeat (2) @(posedge clk);
        #5;
        chk({14'h0, iochrdy_oe_n, rdy}, 16'h0000);
        rd_data_ready = 1'b1;
      end
    join
    #5;
    rd_data_ready = 1'b0;
    chk({15'h0, iochrdy_oe_n}, 16'h0001);
    $display("done mem read");
  endtask

  task t_bios;
    bios_sel = 1'b1;
    fork
      host_u.cyc(2'h0, 16'h0000, 16'h0000, 1'b0);
      begin
        repeat (5) @(posedge clk);
        #5;
        chk({14'h0, iochrdy_oe_n, rdy}, 16'h0001);
      end
    join
    #5;
    bios_sel = 1'b0;
    $display("done bios read");
  endtask

  task t_mem_wr(input logic full);
    wbuf_full = full;
    fork
      host_u.cyc(2'h1, 16'h0000, 16'h0000, 1'b0);
      begin
        repeat (5) @(posedge clk);
        #5;
        chk({14'h0, iochrdy_oe_n, rdy}, {15'h0, !full});
        wbuf_full = 1'b0;
        repeat (2) @(posedge clk);
        #5;
        chk({14'h0, iochrdy_oe_n, rdy}, 16'h0001);
      end
    join
    #5;
    chk({15'h0, iochrdy_oe_n}, 16'h0001);
    $display("done mem write full=%0d", full);
  endtask

  task t_io;
    for (int e = 0; e < 2; e++) begin
      for (int i = 0; i < 12; i++) begin
        fork
          host_u.cyc(2'h2, io_tbl[i], 16'h0000, e[0]);
          begin
            repeat (5) @(posedge clk);
            #5;
            chk({10'h0, iocs16_o, reg_rd_en, iocs16_oe_n, sd_oe_n, iochrdy_oe_n, rdy},
                {10'h0, 1'b0, (i < 11 && e == 0), !(i < 10 && e == 0),
                 {2{!(i < 11 && e == 0)}}, 1'b1});
            if (i < 11 && e == 0) chk(sd_o, 16'hA55A);
          end
        join
      end
    end
    $display("done io read");
  endtask

  task t_io_wr(input logic e);
    int n;
    n = stb_cnt;
    host_u.cyc(2'h3, 16'h03D4, 16'h1234, e);
    repeat (4) @(posedge clk);
    #5;
    chk(16'(stb_cnt - n), {15'h0, !e});
    if (!e) chk(reg_wr_data, 16'h1234);
    if (!e) chk(reg_addr, 16'h03D4);
    $display("done io write aen=%0d", e);
  endtask

  initial begin
    rst = 1'b1;
    bios_sel = 1'b0;
    rd_data_ready = 1'b0;
    wbuf_full = 1'b0;
    reg_rd_data = 16'hA55A;
    repeat (2) @(posedge clk);
    #5;
    rst = 1'b0;
    t_mem_rd;
    t_bios;
    t_mem_wr(1'b0);
    t_mem_wr(1'b1);
    t_io;
    t_io_wr(1'b0);
    t_io_wr(1'b1);
    tally_and_finish;
  end
endmodule
